// ### rtl/irke_pkg.sv
package irke_pkg;

   // Core clock and resonator rates
   localparam int unsigned CLK_FREQ_KHZ = 10000;
   localparam int unsigned OSC_FREQ_KHZ = 455;
   // Core cycles per oscillator period, rounded to nearest
   localparam int unsigned OSC_DIV      = (CLK_FREQ_KHZ + OSC_FREQ_KHZ / 2) / OSC_FREQ_KHZ;

   // Matrix geometry
   localparam int unsigned NUM_DRIVE = 7;
   localparam int unsigned NUM_SENSE = 7;
   localparam logic [2:0] GND_COL      = 3'h7;
   localparam logic [2:0] CARRIER_COL  = 3'h6;
   localparam logic [2:0] LAST_STEP    = 3'h7;
   localparam logic [2:0] ADDR_NONE    = 3'h7;
   localparam logic [2:0] PAIR_ROW     = 3'h7;
   localparam logic [6:0] DRIVE_ALL    = 7'h7f;
   localparam logic [6:0] DRIVE_ONE    = 7'h01;
   localparam logic [6:0] PAIR_MASK    = 7'h60;

   // Pulse train timing in oscillator periods
   localparam int unsigned UNIT_OSC_FLASH   = 1152;
   localparam int unsigned UNIT_OSC_CARRIER = 1536;
   localparam int unsigned WORD_OSC_FLASH   = 55296;
   localparam int unsigned WORD_OSC_CARRIER = 73728;
   localparam logic [1:0]  DIV_MOD_FLASH    = 2'h3;
   localparam logic [1:0]  DIV_MOD_CARRIER  = 2'h0;
   localparam int unsigned UNIT_PRESCALE    = UNIT_OSC_FLASH / 3;
   localparam int unsigned WORD_UNITS       = WORD_OSC_FLASH / UNIT_OSC_FLASH;
   localparam logic [5:0]  WORD_UNITS_M1    = 6'(WORD_UNITS - 1);
   localparam logic [4:0]  FLASH_PULSE_M1   = 5'h03;
   localparam int unsigned CARRIER_BURST    = 8;

   // Bit spacing in units
   localparam logic [1:0] ZERO_UNITS = 2'h2;
   localparam logic [1:0] ONE_UNITS  = 2'h3;
   localparam logic       REF_BIT    = 1'b0;
   localparam logic [3:0] LAST_PULSE = 4'ha;

   // Sequencing in units and oscillator periods
   localparam logic [5:0] DEBOUNCE_M1    = 6'h05;
   localparam logic [1:0] RELEASE_UNITS  = 2'h1;
   localparam logic [5:0] SCAN_MULTI_M1  = 6'h08;
   localparam logic [2:0] SCAN_STEP_M1   = 3'h3;

   typedef enum logic [2:0] {
      ST_STANDBY,
      ST_DEBOUNCE,
      ST_SCAN,
      ST_DECIDE,
      ST_WAIT
   } irke_state_t;

endpackage : irke_pkg

// ### rtl/irke_sync.sv
`timescale 1ns/1ns
`default_nettype none

module irke_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             nrst,
   // Raw and synchronised levels
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);

   typedef struct packed {
      logic [WIDTH-1:0] s1;
      logic [WIDTH-1:0] s2;
   } irke_sync_t;

   irke_sync_t r;
   irke_sync_t next_r;

   always_comb begin
      next_r    = r;
      next_r.s1 = din;
      next_r.s2 = r.s1;
   end

   // Idle level of pulled-up pins is high
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r <= '1;
      end else begin
         r <= next_r;
      end
   end

   assign dout = r.s2;

endmodule : irke_sync

`default_nettype wire

// ### rtl/irke_step_decode.sv
`timescale 1ns/1ns
`default_nettype none

module irke_step_decode (
   // Step context
   input  wire logic       gnd_step,
   input  wire logic [2:0] col,
   input  wire logic [6:0] gnd_mask,
   // Pressed sense lines, high when pulled low
   input  wire logic [6:0] sense_low,
   // Result of this step
   output var  logic [1:0] keys,
   output var  logic [5:0] code
);

   logic [6:0] eff;
   logic [6:0] rest;
   logic       pair;
   logic [2:0] cnt;
   logic [2:0] row;

   always_comb begin
      eff  = gnd_step ? sense_low : (sense_low & ~gnd_mask);
      pair = (eff & irke_pkg::PAIR_MASK) == irke_pkg::PAIR_MASK;
      rest = pair ? (eff & ~irke_pkg::PAIR_MASK) : eff;
      cnt  = {2'b00, pair};
      row  = irke_pkg::PAIR_ROW;
      for (int j = irke_pkg::NUM_SENSE - 1; j >= 0; j--) begin
         if (rest[j]) begin
            cnt = cnt + 3'h1;
            row = 3'(j);
         end
      end
      keys = (cnt > 3'h2) ? 2'h2 : cnt[1:0];
      code = {row, col};
   end

endmodule : irke_step_decode

`default_nettype wire

// ### rtl/irke_encoder.sv
// What this block does
// - In standby all drive lines pull low so any key pulls its sense line.
// - Sense low starts oscillator, waits debounce, then drives lines one by one.
// - First scan latches transmission mode, subsystem address and command code.
// - Address sampled only on first scan; later address input changes ignored.
// - Command code re-sensed every scan and follows the currently pressed key.
// - With several keys pressed no new output word is started.
// - Multiple key condition scans at a faster repetition rate.
// - Sense line grounded masks other keys on it; ground code is sent.
// - Sense lines 5 and 6 together on one drive give codes 56 to 63.
// - Code is eight times sense index plus drive index; ground is drive 7.
// - Valid key sends repeated words with latched address and command.
// - Release or multiple press stops sending, but a started word completes.
// - Toggle counter advances after release of one unit, not in multi sequence.
// - Unit is 1152 periods flashed, 1536 carrier; flash pulse four periods.
// - Divider modulus 3 flashed, 4 carrier; word periods 55296 and 73728.
// - Pulse spacing two units means zero, three units means one.
// - Carrier pulse is a burst of one-period cycles, eight by default.
// - Drive line 6 on address input selects carrier, else flashed.
// - Highest drive 0..5 on address input gives address; none sends 111.
// - Word sends two toggle bits, three address bits, six command bits.
// - Carrier mode replaces first toggle bit by a constant reference spacing.
// - Debounce lasts between four and nine units.
// - Minimum release time for toggle advance is one unit.
`timescale 1ns/1ns
`default_nettype none

module irke_encoder #(
   parameter int unsigned OSC_DIV       = irke_pkg::OSC_DIV,
   parameter int unsigned UNIT_PRESCALE = irke_pkg::UNIT_PRESCALE,
   parameter int unsigned CARRIER_BURST = irke_pkg::CARRIER_BURST
) (
   // Clock and reset
   input  wire logic       mclk,
   input  wire logic       nrst,
   // Key matrix
   input  wire logic [6:0] key_sense_line_n,
   output var  logic [6:0] key_drive_line_out,
   output var  logic [6:0] key_drive_line_oe,
   // Strap wiring, low when tied to a low drive line
   input  wire logic       address_mode_input,
   // LED stage
   output var  logic       ir_pulse_output,
   // Status
   output var  logic       osc_running,
   output var  logic       word_active
);

   localparam logic [7:0] DIV_M1   = 8'(OSC_DIV - 1);
   localparam logic [7:0] DIV_HALF = 8'(OSC_DIV / 2);
   localparam logic [8:0] UNIT_M1  = 9'(UNIT_PRESCALE - 1);
   localparam logic [4:0] BURST_M1 = 5'(CARRIER_BURST - 1);

   typedef struct packed {
      irke_pkg::irke_state_t state;
      logic [7:0]            div_cnt;
      logic [1:0]            pre_cnt;
      logic [8:0]            unit_cnt;
      logic [5:0]            tmr;
      logic [5:0]            period_cnt;
      logic                  period_on;
      logic [2:0]            step;
      logic [2:0]            step_osc;
      logic [6:0]            gnd_mask;
      logic [1:0]            scan_keys;
      logic [5:0]            scan_code;
      logic [2:0]            scan_addr;
      logic                  scan_carrier;
      logic                  first_scan;
      logic                  carrier;
      logic [2:0]            addr;
      logic [5:0]            cmd;
      logic                  multi;
      logic                  sent;
      logic [1:0]            toggle;
      logic [1:0]            rel_cnt;
      logic                  rel_done;
      logic                  word_on;
      logic [10:0]           word;
      logic [3:0]            pulse_idx;
      logic [1:0]            gap_left;
      logic                  pulse_on;
      logic [4:0]            pulse_osc;
      logic [6:0]            drive_oe;
      logic                  ir_out;
      logic                  osc_run;
   } irke_regs_t;

   irke_regs_t r;
   irke_regs_t next_r;

   logic [6:0] sense_sync;
   logic       address_mode_input_sync;
   logic [6:0] sense_low;
   logic       any_key;
   logic [1:0] dec_keys;
   logic [5:0] dec_code;
   logic [2:0] step_col;
   logic       gnd_step;

   irke_sync #(
      .WIDTH (8)
   ) u_sync (
      .mclk (mclk),
      .nrst (nrst),
      .din  ({address_mode_input, key_sense_line_n}),
      .dout ({address_mode_input_sync, sense_sync})
   );

   assign sense_low = ~sense_sync;
   assign any_key   = |sense_low;
   assign gnd_step  = (r.step == 3'h0);
   assign step_col  = gnd_step ? irke_pkg::GND_COL : (r.step - 3'h1);

   irke_step_decode u_dec (
      .gnd_step  (gnd_step),
      .col       (step_col),
      .gnd_mask  (r.gnd_mask),
      .sense_low (sense_low),
      .keys      (dec_keys),
      .code      (dec_code)
   );

   logic       osc_tick;
   logic       unit_tick;
   logic       fire;
   logic       start_scan;
   logic [1:0] pre_max;
   logic [4:0] plen_m1;
   logic [2:0] addr_now;
   logic       carrier_now;
   logic [2:0] keys_sum;

   always_comb begin
      next_r      = r;
      osc_tick    = 1'b0;
      unit_tick   = 1'b0;
      fire        = 1'b0;
      start_scan  = 1'b0;
      addr_now    = r.first_scan ? r.scan_addr : r.addr;
      carrier_now = r.first_scan ? r.scan_carrier : r.carrier;
      keys_sum    = {1'b0, r.scan_keys} + {1'b0, dec_keys};
      // Modulus 3 flashed, 4 carrier, so carrier units and words are a third longer
      pre_max     = (r.carrier ? irke_pkg::DIV_MOD_CARRIER : irke_pkg::DIV_MOD_FLASH) - 2'h1;
      plen_m1     = r.carrier ? BURST_M1 : irke_pkg::FLASH_PULSE_M1;

      // Oscillator only runs while awake
      if (r.osc_run) begin
         if (r.div_cnt == DIV_M1) begin
            next_r.div_cnt = '0;
            osc_tick       = 1'b1;
         end else begin
            next_r.div_cnt = r.div_cnt + 8'h01;
         end
      end else begin
         next_r.div_cnt = '0;
      end
      if (osc_tick) begin
         if (r.pre_cnt == pre_max) begin
            next_r.pre_cnt = '0;
            if (r.unit_cnt == UNIT_M1) begin
               next_r.unit_cnt = '0;
               unit_tick       = 1'b1;
            end else begin
               next_r.unit_cnt = r.unit_cnt + 9'h001;
            end
         end else begin
            next_r.pre_cnt = r.pre_cnt + 2'h1;
         end
      end

      // Release watch needs all drives low, so it pauses during scans
      if (r.osc_run && r.state != irke_pkg::ST_SCAN) begin
         if (any_key) begin
            next_r.rel_cnt  = '0;
            next_r.rel_done = 1'b0;
         end else if (unit_tick && !r.rel_done) begin
            // First tick only ends a partial unit, so one more is needed
            if (r.rel_cnt == irke_pkg::RELEASE_UNITS) begin
               next_r.rel_done = 1'b1;
               if (r.sent) begin
                  next_r.toggle = r.toggle + 2'h1;
               end
            end else begin
               next_r.rel_cnt = r.rel_cnt + 2'h1;
            end
         end
      end

      // Word period from start of one word to the next
      if (r.period_on && unit_tick) begin
         if (r.period_cnt == irke_pkg::WORD_UNITS_M1) begin
            next_r.period_on = 1'b0;
         end else begin
            next_r.period_cnt = r.period_cnt + 6'h01;
         end
      end

      // Pulse distance serialiser
      if (r.word_on && unit_tick) begin
         if (r.gap_left == 2'h1) begin
            fire             = 1'b1;
            next_r.pulse_idx = r.pulse_idx + 4'h1;
            next_r.word      = {r.word[9:0], 1'b0};
            if (r.pulse_idx == irke_pkg::LAST_PULSE) begin
               next_r.word_on = 1'b0;
            end else begin
               next_r.gap_left = r.word[9] ? irke_pkg::ONE_UNITS : irke_pkg::ZERO_UNITS;
            end
         end else begin
            next_r.gap_left = r.gap_left - 2'h1;
         end
      end

      unique case (r.state)
         irke_pkg::ST_STANDBY: begin
            if (any_key) begin
               next_r.state      = irke_pkg::ST_DEBOUNCE;
               next_r.osc_run    = 1'b1;
               next_r.tmr        = '0;
               next_r.first_scan = 1'b1;
               next_r.unit_cnt   = '0;
               next_r.pre_cnt    = '0;
            end
         end
         irke_pkg::ST_DEBOUNCE: begin
            if (unit_tick) begin
               if (r.tmr == irke_pkg::DEBOUNCE_M1) begin
                  start_scan = 1'b1;
               end else begin
                  next_r.tmr = r.tmr + 6'h01;
               end
            end
         end
         irke_pkg::ST_SCAN: begin
            if (osc_tick) begin
               if (r.step_osc == irke_pkg::SCAN_STEP_M1) begin
                  next_r.step_osc = '0;
                  if (gnd_step) begin
                     next_r.gnd_mask  = sense_low;
                     next_r.scan_keys = dec_keys;
                  end else begin
                     next_r.scan_keys = (keys_sum > 3'h2) ? 2'h2 : keys_sum[1:0];
                     // Later, higher drives overwrite, so the highest wins
                     if (!address_mode_input_sync && step_col < irke_pkg::CARRIER_COL) begin
                        next_r.scan_addr = step_col;
                     end
                     if (!address_mode_input_sync && step_col == irke_pkg::CARRIER_COL) begin
                        next_r.scan_carrier = 1'b1;
                     end
                  end
                  if (dec_keys == 2'h1) begin
                     next_r.scan_code = dec_code;
                  end
                  if (r.step == irke_pkg::LAST_STEP) begin
                     next_r.state = irke_pkg::ST_DECIDE;
                  end else begin
                     next_r.step = r.step + 3'h1;
                  end
               end else begin
                  next_r.step_osc = r.step_osc + 3'h1;
               end
            end
         end
         irke_pkg::ST_DECIDE: begin
            if (r.first_scan) begin
               next_r.addr       = r.scan_addr;
               next_r.carrier    = r.scan_carrier;
               next_r.first_scan = 1'b0;
            end
            next_r.tmr   = '0;
            next_r.state = irke_pkg::ST_WAIT;
            if (r.scan_keys == 2'h0) begin
               // Only reached once the word period is over
               next_r.state   = irke_pkg::ST_STANDBY;
               next_r.osc_run = 1'b0;
               next_r.carrier = 1'b0;
               next_r.multi   = 1'b0;
               next_r.sent    = 1'b0;
               if (r.sent && !r.rel_done) begin
                  next_r.toggle = r.toggle + 2'h1;
               end
            end else if (r.scan_keys == 2'h2) begin
               next_r.multi = 1'b1;
            end else begin
               next_r.multi = 1'b0;
               next_r.cmd   = r.scan_code;
               if (!r.period_on && !r.word_on) begin
                  next_r.word       = {carrier_now ? irke_pkg::REF_BIT : r.toggle[1],
                                       r.toggle[0], addr_now, r.scan_code};
                  next_r.word_on    = 1'b1;
                  next_r.sent       = 1'b1;
                  next_r.period_on  = 1'b1;
                  next_r.period_cnt = '0;
                  next_r.pulse_idx  = '0;
                  next_r.gap_left   = ((!carrier_now && r.toggle[1]) ?
                                       irke_pkg::ONE_UNITS : irke_pkg::ZERO_UNITS);
                  next_r.div_cnt    = '0;
                  next_r.pre_cnt    = '0;
                  next_r.unit_cnt   = '0;
                  fire              = 1'b1;
               end
            end
         end
         irke_pkg::ST_WAIT: begin
            if (r.multi) begin
               if (unit_tick) begin
                  if (r.tmr == irke_pkg::SCAN_MULTI_M1) begin
                     start_scan = 1'b1;
                  end else begin
                     next_r.tmr = r.tmr + 6'h01;
                  end
               end
            end else if (!r.period_on && !r.word_on) begin
               // A started word always runs to its end first
               start_scan = 1'b1;
            end
         end
      endcase

      if (start_scan) begin
         next_r.state        = irke_pkg::ST_SCAN;
         next_r.step         = '0;
         next_r.step_osc     = '0;
         next_r.scan_keys    = '0;
         next_r.gnd_mask     = '0;
         next_r.scan_addr    = irke_pkg::ADDR_NONE;
         next_r.scan_carrier = 1'b0;
      end

      if (fire) begin
         next_r.pulse_on  = 1'b1;
         next_r.pulse_osc = '0;
      end else if (r.pulse_on && osc_tick) begin
         if (r.pulse_osc == plen_m1) begin
            next_r.pulse_on = 1'b0;
         end else begin
            next_r.pulse_osc = r.pulse_osc + 5'h01;
         end
      end

      // Carrier cycles are high for the first half of each period
      next_r.ir_out = next_r.pulse_on &&
                      (!next_r.carrier || next_r.div_cnt < DIV_HALF);

      // Step 0 drives nothing so only grounded keys show
      if (next_r.state == irke_pkg::ST_SCAN) begin
         if (next_r.step == 3'h0) begin
            next_r.drive_oe = '0;
         end else begin
            next_r.drive_oe = irke_pkg::DRIVE_ONE << (next_r.step - 3'h1);
         end
      end else begin
         next_r.drive_oe = irke_pkg::DRIVE_ALL;
      end
   end

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         r          <= '0;
         r.state    <= irke_pkg::ST_STANDBY;
         r.drive_oe <= irke_pkg::DRIVE_ALL;
         r.addr     <= irke_pkg::ADDR_NONE;
      end else begin
         r <= next_r;
      end
   end

   // Open drain: the data line is a constant low register
   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         key_drive_line_out <= '0;
      end else begin
         key_drive_line_out <= '0;
      end
   end

   assign key_drive_line_oe = r.drive_oe;
   assign ir_pulse_output   = r.ir_out;
   assign osc_running       = r.osc_run;
   assign word_active       = r.word_on;

endmodule : irke_encoder

`default_nettype wire

// ### test/irke_assertions.sv
`timescale 1ns/1ns
`default_nettype none

module irke_assertions #(
   parameter int unsigned OSC_DIV       = 2,
   parameter int unsigned UNIT_PRESCALE = 4
) (
   // Clock and reset
   input wire logic       mclk,
   input wire logic       nrst,
   // Key matrix and strap
   input wire logic [6:0] key_sense_line_n,
   input wire logic [6:0] key_drive_line_out,
   input wire logic [6:0] key_drive_line_oe,
   input wire logic       address_mode_input,
   // LED stage and status
   input wire logic       ir_pulse_output,
   input wire logic       osc_running,
   input wire logic       word_active
);
   localparam int UF = 3 * UNIT_PRESCALE * OSC_DIV;
   localparam int UC = 4 * UNIT_PRESCALE * OSC_DIV;
   logic [15:0] awake;
   logic [15:0] since_w;
   logic        scanned;
   logic        seen;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);

   always_ff @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         awake   <= 16'h0000;
         since_w <= 16'h0000;
         scanned <= 1'b0;
         seen    <= 1'b0;
      end else begin
         awake   <= osc_running ? awake + 16'h0001 : 16'h0000;
         scanned <= osc_running && (scanned || key_drive_line_oe != 7'h7f);
         if ($rose(word_active)) begin
            since_w <= 16'h0001;
            seen    <= 1'b1;
         end else if (since_w != 16'hffff) begin
            since_w <= since_w + 16'h0001;
         end
      end
   end

   drive_low_a: assert property (!osc_running |-> key_drive_line_oe == 7'h7f)
      else $error("drive lines released in standby");
   drive_data_a: assert property (key_drive_line_out == 7'h00)
      else $error("drive data not low");
   wake_up_a: assert property ((!osc_running && key_sense_line_n != 7'h7f)[*3]
      |-> ##[0:2] osc_running) else $error("no wake on key");
   debounce_len_a: assert property (osc_running && !scanned && key_drive_line_oe != 7'h7f
      |-> awake >= 4 * UF && awake <= 9 * UF) else $error("debounce length wrong");
   scan_order_a: assert property (osc_running && $changed(key_drive_line_oe)
      && key_drive_line_oe != 7'h7f && key_drive_line_oe != 7'h00
      |-> $past(key_drive_line_oe) == key_drive_line_oe >> 1) else $error("scan order wrong");
   // Step of four oscillator ticks, eight cycles at the shortened divider
   step_hold_a: assert property ($changed(key_drive_line_oe) && key_drive_line_oe != 7'h7f
      && key_drive_line_oe != 7'h00 |=> $stable(key_drive_line_oe)[*7])
      else $error("scan step too short");
   // Ground step may start mid oscillator period, so it can be one cycle short
   scan_entry_a: assert property ($changed(key_drive_line_oe)
      && key_drive_line_oe == 7'h00 |=> $stable(key_drive_line_oe)[*6])
      else $error("ground step too short");
   idle_quiet_a: assert property (!osc_running |-> !ir_pulse_output && !word_active)
      else $error("output active in standby");
   flash_width_a: assert property ($rose(ir_pulse_output) ##1 ir_pulse_output
      |=> ir_pulse_output[*6] ##1 !ir_pulse_output) else $error("flash pulse width wrong");
   word_start_a: assert property ($rose(word_active) |-> ir_pulse_output)
      else $error("word without pulse");
   word_period_a: assert property ($rose(word_active) && seen |-> since_w >= 48 * UF)
      else $error("word period too short");
   word_len_a: assert property ($fell(word_active)
      |-> since_w >= 22 * UF && since_w <= 33 * UC + 4) else $error("word length wrong");

   cover property ($rose(word_active));
   cover property ($rose(ir_pulse_output) ##1 !ir_pulse_output);
   cover property (key_drive_line_oe == 7'h40);
endmodule : irke_assertions

bind irke_encoder irke_assertions #(
   .OSC_DIV      (OSC_DIV),
   .UNIT_PRESCALE(UNIT_PRESCALE)
) chk (
   .mclk(mclk), .nrst(nrst), .key_sense_line_n(key_sense_line_n),
   .key_drive_line_out(key_drive_line_out), .key_drive_line_oe(key_drive_line_oe),
   .address_mode_input(address_mode_input), .ir_pulse_output(ir_pulse_output),
   .osc_running(osc_running), .word_active(word_active)
);

`default_nettype wire

// ### test/irke_partner.sv
`timescale 1ns/1ns
`default_nettype none

module irke_partner #(
   parameter int unsigned OSC_DIV       = 2,
   parameter int unsigned UNIT_PRESCALE = 4
) (
   // Clock and reset
   input  wire logic        mclk,
   input  wire logic        nrst,
   // Matrix pins
   input  wire logic [6:0]  drive_oe,
   output var  logic [6:0]  sense_n,
   output var  logic        addr_mode,
   // Pressed keys by code, strap wiring by drive line
   input  wire logic [63:0] keys,
   input  wire logic [6:0]  strap,
   // LED stage
   input  wire logic        ir,
   output var  logic [10:0] word,
   output var  int          words,
   output var  int          bad
);
   logic [7:0]  drv;
   logic [10:0] bits;
   int          gap;
   int          low_run;
   int          n;
   int          u;

   assign drv = {1'b1, drive_oe};

   always_comb begin
      for (int s = 0; s < 7; s++) begin
         sense_n[s] = ~|(keys[s * 8 +: 8] & drv);
      end
      sense_n[5] = sense_n[5] & ~|(keys[63:56] & drv);
      sense_n[6] = sense_n[6] & ~|(keys[63:56] & drv);
      // Pull-down holds the strap low while every driver is on
      addr_mode = (drive_oe == 7'h7f) ? 1'b0 : ~|(strap & drive_oe);
   end

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         gap = 9999;
         low_run = 99;
         n = 0;
         bits = 11'h000;
         word = 11'h000;
         words = 0;
         bad = 0;
      end else begin
         u = (strap[6] ? 4 : 3) * UNIT_PRESCALE * OSC_DIV;
         // Carrier gaps inside a burst are one cycle, so only long lows mark a new pulse
         if (ir && low_run > 3) begin
            if (gap > 5 * u) begin
               n = 0;
            end else begin
               bits = {bits[9:0], gap > 5 * u / 2};
               n++;
               if (gap != 2 * u && gap != 3 * u) begin
                  bad++;
               end
            end
            if (n == 11) begin
               word = bits;
               words++;
            end
            gap = 0;
         end
         gap++;
         low_run = ir ? 0 : low_run + 1;
      end
   end
endmodule : irke_partner

`default_nettype wire

// ### test/testbench.sv
`timescale 1ns/1ns
`default_nettype none

module testbench;
   logic        mclk;
   logic        nrst;
   logic        addr_mode;
   logic        ir;
   logic        osc_running;
   logic        word_active;
   logic [6:0]  sense_n;
   logic [6:0]  drv_out;
   logic [6:0]  drv_oe;
   logic [6:0]  strap;
   logic [63:0] keys;
   logic [10:0] word;
   int          words;
   int          bad;
   int          errors;
   int          comparisons;
   int          cycles;

   irke_encoder #(.OSC_DIV(2), .UNIT_PRESCALE(4), .CARRIER_BURST(8)) dut (
      .mclk(mclk), .nrst(nrst), .key_sense_line_n(sense_n),
      .key_drive_line_out(drv_out), .key_drive_line_oe(drv_oe),
      .address_mode_input(addr_mode), .ir_pulse_output(ir),
      .osc_running(osc_running), .word_active(word_active)
   );

   irke_partner #(.OSC_DIV(2), .UNIT_PRESCALE(4)) keypad (
      .mclk(mclk), .nrst(nrst), .drive_oe(drv_oe), .sense_n(sense_n),
      .addr_mode(addr_mode), .keys(keys), .strap(strap), .ir(ir),
      .word(word), .words(words), .bad(bad)
   );

   initial begin
      mclk = 1'b0;
      forever #50 mclk = ~mclk;
   end

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task automatic results;
      if (errors == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : results

   task automatic tick;
      @(posedge mclk);
      #10;
   endtask : tick

   task automatic press(input logic [63:0] k, input logic [6:0] s);
      tick();
      keys = k;
      strap = s;
   endtask : press

   task automatic wait_word(input logic [10:0] exp);
      int n0;
      n0 = words;
      for (int i = 0; i < 4000 && words == n0; i++) tick();
      check("word seen", {15'h0000, words != n0}, 16'h0001);
      check("word", {5'h00, word}, {5'h00, exp});
   endtask : wait_word

   task automatic idle;
      press(64'h0, strap);
      for (int i = 0; i < 4000 && osc_running !== 1'b0; i++) tick();
      check("standby osc", {15'h0000, osc_running}, 16'h0000);
      check("standby drive", {9'h000, drv_oe}, 16'h007f);
      check("drive data", {9'h000, drv_out}, 16'h0000);
   endtask : idle

   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         results();
      end
   end

   initial begin
      int n0;
      nrst = 1'b0;
      keys = 64'h0;
      strap = 7'h00;
      errors = 0;
      comparisons = 0;
      cycles = 0;
      repeat (20) @(posedge mclk);
      #10;
      nrst = 1'b1;
      repeat (4) tick();
      press(64'h1 << 1, 7'h00);
      wait_word(11'h1c1);
      idle();
      // Carrier strap, then address strap moved while held
      press(64'h1 << 35, 7'h44);
      wait_word(11'h2a3);
      press(64'h1 << 35, 7'h41);
      wait_word(11'h2a3);
      idle();
      // Two keys on different sense lines, then one released
      press((64'h1 << 9) | (64'h1 << 18), 7'h00);
      n0 = words;
      repeat (3000) tick();
      check("multi words", 16'(words - n0), 16'h0000);
      press(64'h1 << 9, 7'h00);
      wait_word(11'h5c9);
      idle();
      press((64'h1 << 23) | (64'h1 << 16), 7'h00);
      wait_word(11'h7d7);
      idle();
      // Release right after the word starts
      press(64'h1 << 60, 7'h00);
      for (int i = 0; i < 3000 && word_active !== 1'b1; i++) tick();
      press(64'h0, 7'h00);
      wait_word(11'h1fc);
      check("spacing", 16'(bad), 16'h0000);
      idle();
      results();
   end
endmodule : testbench

`default_nettype wire
